// ### hw/twrp_pkg.sv
// constants and types shared by the three-wire register port files
package twrp_pkg;

    // ------------------------------------------------------------
    // frame layout, counted in serial clock rising edges
    // ------------------------------------------------------------
    localparam int unsigned TWRP_CNT_W      = 6;
    localparam int unsigned TWRP_ADDR_BITS  = 12;
    localparam int unsigned TWRP_ZERO_BITS  = 8;
    localparam int unsigned TWRP_IDX_W      = 4;
    localparam int unsigned TWRP_NUM_REGS   = 16;
    localparam int unsigned TWRP_DATA_W     = 32;

    localparam logic [5:0] TWRP_CNT_ADDR_LAST = 6'h0C;  // 12th edge: address done
    localparam logic [5:0] TWRP_CNT_DIR       = 6'h0D;  // 13th edge: direction flag
    localparam logic [5:0] TWRP_CNT_TA_LAST   = 6'h10;  // 16th edge: last turnaround
    localparam logic [5:0] TWRP_CNT_FRAME     = 6'h30;  // 48th edge: frame complete
    localparam logic [5:0] TWRP_CNT_ONE       = 6'h01;

    localparam logic [31:0] TWRP_REG_RESET   = 32'h0000_0000;
    localparam logic [7:0]  TWRP_ADDR_ZEROS  = 8'h00;

    // ------------------------------------------------------------
    // termination mode pin encoding
    // ------------------------------------------------------------
    localparam logic [1:0] TWRP_TERM_PULLUP   = 2'h0;
    localparam logic [1:0] TWRP_TERM_PULLDOWN = 2'h1;
    localparam logic [1:0] TWRP_TERM_KEEPER   = 2'h2;

    typedef logic [TWRP_CNT_W-1:0]  twrp_cnt_t;
    typedef logic [TWRP_IDX_W-1:0]  twrp_idx_t;
    typedef logic [TWRP_DATA_W-1:0] twrp_word_t;

    // frame phases of the link
    typedef enum logic [2:0] {
        TWRP_PH_ADDR,
        TWRP_PH_DIR,
        TWRP_PH_TURN,
        TWRP_PH_DATA,
        TWRP_PH_DONE
    } twrp_phase_t;

endpackage

// ### hw/twrp_reg_if.sv
// carrier between the port control logic and the register store
`timescale 1ns/1ps
interface twrp_reg_if;
    import twrp_pkg::*;

    logic                                  wrStrobe;
    twrp_idx_t                             wrIndex;
    twrp_word_t                            wrWord;
    twrp_idx_t                             rdIndex;
    twrp_word_t                            rdWord;
    logic [TWRP_NUM_REGS*TWRP_DATA_W-1:0]  allWords;

    modport ctrl  (output wrStrobe, output wrIndex, output wrWord, output rdIndex,
                   input rdWord, input allWords);
    modport store (input wrStrobe, input wrIndex, input wrWord, input rdIndex,
                   output rdWord, output allWords);
endinterface

// ### hw/twrp_reg_store.sv
// sixteen 32-bit configuration registers on the system clock
`timescale 1ns/1ps
module twrp_reg_store (
    // system
    input  wire logic mclk,
    input  wire logic rst_n,
    // control side
    twrp_reg_if.store bus
);
    import twrp_pkg::*;

    twrp_word_t regs_ff    [TWRP_NUM_REGS];
    twrp_word_t nxt_regs   [TWRP_NUM_REGS];

    // ------------------------------------------------------------
    // one register per entry
    // ------------------------------------------------------------
    for (genvar i = 0; i < TWRP_NUM_REGS; i++) begin : g_reg
        // a word changes only on a completed write frame
        always_comb begin
            nxt_regs[i] = regs_ff[i];
            if (bus.wrStrobe && (bus.wrIndex == twrp_idx_t'(i))) begin
                nxt_regs[i] = bus.wrWord;
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                regs_ff[i] <= TWRP_REG_RESET;
            end else begin
                regs_ff[i] <= nxt_regs[i];
            end
        end

        assign bus.allWords[i*TWRP_DATA_W +: TWRP_DATA_W] = regs_ff[i];
    end

    // read lookup; the caller latches it
    assign bus.rdWord = regs_ff[bus.rdIndex];

endmodule // twrp_reg_store

// ### hw/twrp_port.sv
// three-wire serial register port: link shifter, crossings, termination
`timescale 1ns/1ps
module twrp_port
    import twrp_pkg::*;
(
    // system clock domain
    input  wire logic                                          mclk,
    input  wire logic                                          rst_n,
    // serial link pins
    input  wire logic                                          serialClk,
    input  wire logic                                          chipSelectLow_n,
    input  wire logic                                          serialDataIoIn,
    output logic                                               serialDataIoOut,
    output logic                                               serialDataIoOe,
    // weak termination control
    input  wire logic [1:0]                                    termMode,
    output logic                                               termPullUpEn,
    output logic                                               termPullDownEn,
    output logic                                               termKeepEn,
    // register contents towards the receiver
    output logic [twrp_pkg::TWRP_NUM_REGS*twrp_pkg::TWRP_DATA_W-1:0] cfgWords
);
    import twrp_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    twrp_reg_if bus ();

    logic        linkRst_n;       // cleared by system reset or released select

    // rising-edge frame state (cleared with select)
    twrp_cnt_t   bitCnt_ff;
    twrp_cnt_t   nxt_bitCnt;
    twrp_phase_t phase_ff;
    twrp_phase_t nxt_phase;
    logic [11:0] addr_ff;
    logic [11:0] nxt_addr;
    logic        isRead_ff;
    logic        nxt_isRead;
    twrp_word_t  dataIn_ff;
    twrp_word_t  nxt_dataIn;

    // rising-edge crossing state (survives select)
    logic        rdToggle_ff;
    logic        nxt_rdToggle;
    twrp_idx_t   rdIdx_ff;
    twrp_idx_t   nxt_rdIdx;
    logic        wrToggle_ff;
    logic        nxt_wrToggle;
    twrp_idx_t   wrIdx_ff;
    twrp_idx_t   nxt_wrIdx;
    twrp_word_t  wrWord_ff;
    twrp_word_t  nxt_wrWord;
    logic        addrOk;

    // falling-edge driver state
    logic        driveEn_ff;
    logic        nxt_driveEn;
    twrp_word_t  outShift_ff;
    twrp_word_t  nxt_outShift;

    // system clock side
    logic        rdSync1_ff;
    logic        rdSync2_ff;
    logic        rdSeen_ff;
    logic        wrSync1_ff;
    logic        wrSync2_ff;
    logic        wrSeen_ff;
    logic        nxt_rdSync1;
    logic        nxt_rdSync2;
    logic        nxt_rdSeen;
    logic        nxt_wrSync1;
    logic        nxt_wrSync2;
    logic        nxt_wrSeen;
    twrp_word_t  rdHold_ff;
    twrp_word_t  nxt_rdHold;
    logic [1:0]  termSync1_ff;
    logic [1:0]  termSync2_ff;
    logic [1:0]  nxt_termSync1;
    logic [1:0]  nxt_termSync2;
    logic        rdEvent;
    logic        wrEvent;

    // ------------------------------------------------------------
    // link reset
    // ------------------------------------------------------------
    // a released select clears the frame state at once, so a stray clock
    // with select high moves nothing and the next frame starts at bit 1
    assign linkRst_n = rst_n & ~chipSelectLow_n;

    // ------------------------------------------------------------
    // rising edge: sample the host's bits
    // ------------------------------------------------------------
    // count saturates at the frame length so extra pulses are ignored
    always_comb begin
        nxt_bitCnt = bitCnt_ff;
        nxt_addr   = addr_ff;
        nxt_isRead = isRead_ff;
        nxt_dataIn = dataIn_ff;
        nxt_phase  = phase_ff;
        if (bitCnt_ff != TWRP_CNT_FRAME) begin
            nxt_bitCnt = bitCnt_ff + TWRP_CNT_ONE;
        end
        case (phase_ff)
            TWRP_PH_ADDR: begin
                nxt_addr = {addr_ff[10:0], serialDataIoIn};
                if (nxt_bitCnt == TWRP_CNT_ADDR_LAST) begin
                    nxt_phase = TWRP_PH_DIR;
                end
            end
            TWRP_PH_DIR: begin
                nxt_isRead = serialDataIoIn;
                nxt_phase  = TWRP_PH_TURN;
            end
            TWRP_PH_TURN: begin
                // turnaround bit values are don't care
                if (nxt_bitCnt == TWRP_CNT_TA_LAST) begin
                    nxt_phase = TWRP_PH_DATA;
                end
            end
            TWRP_PH_DATA: begin
                nxt_dataIn = {dataIn_ff[30:0], serialDataIoIn};
                if (nxt_bitCnt == TWRP_CNT_FRAME) begin
                    nxt_phase = TWRP_PH_DONE;
                end
            end
            TWRP_PH_DONE: begin
                nxt_phase = TWRP_PH_DONE;
            end
            default: begin
                nxt_phase = TWRP_PH_ADDR;
            end
        endcase
    end

    always_ff @(posedge serialClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            bitCnt_ff <= '0;
            phase_ff  <= TWRP_PH_ADDR;
            addr_ff   <= '0;
            isRead_ff <= 1'b0;
            dataIn_ff <= '0;
        end else begin
            bitCnt_ff <= nxt_bitCnt;
            phase_ff  <= nxt_phase;
            addr_ff   <= nxt_addr;
            isRead_ff <= nxt_isRead;
            dataIn_ff <= nxt_dataIn;
        end
    end

    // ------------------------------------------------------------
    // rising edge: requests towards the system clock
    // ------------------------------------------------------------
    // only the low index bits select a register; a frame whose leading
    // address bits are not all zero writes nothing
    assign addrOk = (addr_ff[11:4] == TWRP_ADDR_ZEROS);

    // toggles are not cleared by select, else a release would look like
    // a request on the far side
    always_comb begin
        nxt_rdToggle = rdToggle_ff;
        nxt_rdIdx    = rdIdx_ff;
        nxt_wrToggle = wrToggle_ff;
        nxt_wrIdx    = wrIdx_ff;
        nxt_wrWord   = wrWord_ff;
        if (linkRst_n && (nxt_bitCnt == TWRP_CNT_ADDR_LAST)
            && (bitCnt_ff != TWRP_CNT_ADDR_LAST)) begin
            nxt_rdToggle = ~rdToggle_ff;
            nxt_rdIdx    = nxt_addr[3:0];
        end
        if (linkRst_n && (nxt_bitCnt == TWRP_CNT_FRAME) && (bitCnt_ff != TWRP_CNT_FRAME)
            && !isRead_ff && addrOk) begin
            nxt_wrToggle = ~wrToggle_ff;
            nxt_wrIdx    = addr_ff[3:0];
            nxt_wrWord   = nxt_dataIn;
        end
    end

    always_ff @(posedge serialClk or negedge rst_n) begin
        if (!rst_n) begin
            rdToggle_ff <= 1'b0;
            rdIdx_ff    <= '0;
            wrToggle_ff <= 1'b0;
            wrIdx_ff    <= '0;
            wrWord_ff   <= TWRP_REG_RESET;
        end else begin
            rdToggle_ff <= nxt_rdToggle;
            rdIdx_ff    <= nxt_rdIdx;
            wrToggle_ff <= nxt_wrToggle;
            wrIdx_ff    <= nxt_wrIdx;
            wrWord_ff   <= nxt_wrWord;
        end
    end

    // ------------------------------------------------------------
    // falling edge: drive read data
    // ------------------------------------------------------------
    // rdHold_ff is settled well before the first data bit: it is loaded a
    // few system clocks after the 12th rise, and the load comes four and a
    // half serial periods later (four periods to the 16th rise, then the half period to its fall)
    always_comb begin
        nxt_driveEn  = driveEn_ff;
        nxt_outShift = outShift_ff;
        if (!driveEn_ff && isRead_ff && (bitCnt_ff == TWRP_CNT_TA_LAST)) begin
            nxt_driveEn  = 1'b1;
            nxt_outShift = rdHold_ff;
        end else if (driveEn_ff && (bitCnt_ff == TWRP_CNT_FRAME)) begin
            nxt_driveEn  = 1'b0;
        end else if (driveEn_ff) begin
            nxt_outShift = {outShift_ff[30:0], 1'b0};
        end
    end

    always_ff @(negedge serialClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            driveEn_ff  <= 1'b0;
            outShift_ff <= '0;
        end else begin
            driveEn_ff  <= nxt_driveEn;
            outShift_ff <= nxt_outShift;
        end
    end

    // the select gate releases the line at once even mid-frame
    assign serialDataIoOe  = driveEn_ff & ~chipSelectLow_n;
    assign serialDataIoOut = outShift_ff[31];

    // ------------------------------------------------------------
    // system clock: synchronise toggles and termination pins
    // ------------------------------------------------------------
    // first stages feed only the second stages
    always_comb begin
        nxt_rdSync1   = rdToggle_ff;
        nxt_rdSync2   = rdSync1_ff;
        nxt_rdSeen    = rdSync2_ff;
        nxt_wrSync1   = wrToggle_ff;
        nxt_wrSync2   = wrSync1_ff;
        nxt_wrSeen    = wrSync2_ff;
        nxt_termSync1 = termMode;
        nxt_termSync2 = termSync1_ff;
        nxt_rdHold    = rdHold_ff;
        if (rdEvent) begin
            nxt_rdHold = bus.rdWord;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdSync1_ff   <= 1'b0;
            rdSync2_ff   <= 1'b0;
            rdSeen_ff    <= 1'b0;
            wrSync1_ff   <= 1'b0;
            wrSync2_ff   <= 1'b0;
            wrSeen_ff    <= 1'b0;
            termSync1_ff <= TWRP_TERM_PULLUP;
            termSync2_ff <= TWRP_TERM_PULLUP;
            rdHold_ff    <= TWRP_REG_RESET;
        end else begin
            rdSync1_ff   <= nxt_rdSync1;
            rdSync2_ff   <= nxt_rdSync2;
            rdSeen_ff    <= nxt_rdSeen;
            wrSync1_ff   <= nxt_wrSync1;
            wrSync2_ff   <= nxt_wrSync2;
            wrSeen_ff    <= nxt_wrSeen;
            termSync1_ff <= nxt_termSync1;
            termSync2_ff <= nxt_termSync2;
            rdHold_ff    <= nxt_rdHold;
        end
    end

    assign rdEvent = rdSync2_ff ^ rdSeen_ff;
    assign wrEvent = wrSync2_ff ^ wrSeen_ff;

    // ------------------------------------------------------------
    // register store hookup
    // ------------------------------------------------------------
    // index and word are held in the link domain until the next frame,
    // long after the synchronised toggle is seen
    assign bus.wrStrobe = wrEvent;
    assign bus.wrIndex  = wrIdx_ff;
    assign bus.wrWord   = wrWord_ff;
    assign bus.rdIndex  = rdIdx_ff;
    assign cfgWords     = bus.allWords;

    twrp_reg_store u_store (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (bus.store)
    );

    // ------------------------------------------------------------
    // weak termination
    // ------------------------------------------------------------
    // at most one weak element is on, and never while the port drives
    always_comb begin
        termPullUpEn   = 1'b0;
        termPullDownEn = 1'b0;
        termKeepEn     = 1'b0;
        if (!serialDataIoOe) begin
            case (termSync2_ff)
                TWRP_TERM_PULLUP:   termPullUpEn   = 1'b1;
                TWRP_TERM_PULLDOWN: termPullDownEn = 1'b1;
                TWRP_TERM_KEEPER:   termKeepEn     = 1'b1;
                default:            termPullUpEn   = 1'b0;  // no termination
            endcase
        end
    end

endmodule // twrp_port

// ### bench/twrp_port_monitor.sv
// checker bound to the three-wire register port top
`timescale 1ns/1ps
module twrp_port_monitor
    import twrp_pkg::*;
(
    // system
    input wire logic         mclk,
    input wire logic         rst_n,
    // link pins
    input wire logic         serialClk,
    input wire logic         chipSelectLow_n,
    input wire logic         serialDataIoIn,
    input wire logic         serialDataIoOut,
    input wire logic         serialDataIoOe,
    // termination
    input wire logic [1:0]   termMode,
    input wire logic         termPullUpEn,
    input wire logic         termPullDownEn,
    input wire logic         termKeepEn,
    // registers
    input wire logic [511:0] cfgWords
);
    // ------
    // shadow of the frame; count and direction are cleared by select as the port's are
    // ------
    logic [5:0]  cnt_ff;
    logic        rd_ff;
    logic [11:0] adr_ff;
    logic [31:0] dat_ff;
    logic        tgl_ff;
    logic [3:0]  wAdr_ff;
    logic [31:0] wDat_ff;
    logic [2:0]  sync_ff;
    logic [3:0]  since_ff;
    logic        rdWin;
    logic [2:0]  termExp;
    assign rdWin   = rd_ff && cnt_ff >= 6'h10 && cnt_ff <= 6'h2F;
    assign termExp = {termMode == 2'h0, termMode == 2'h1, termMode == 2'h2};

    // rise count, address, direction and data as the host sent them
    always_ff @(posedge serialClk or posedge chipSelectLow_n) begin
        if (chipSelectLow_n) begin
            cnt_ff <= 6'h00;
            rd_ff  <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 6'h01;
            if (cnt_ff < 6'h0C) adr_ff <= {adr_ff[10:0], serialDataIoIn};
            if (cnt_ff == 6'h0C) rd_ff <= serialDataIoIn;
            if (cnt_ff >= 6'h10) dat_ff <= {dat_ff[30:0], serialDataIoIn};
        end
    end

    // a complete, well addressed write flips the toggle at rise 48
    always_ff @(posedge serialClk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_ff <= 1'b0;
        end else if (!chipSelectLow_n && cnt_ff == 6'h2F && !rd_ff && adr_ff[11:4] == 8'h00) begin
            tgl_ff  <= ~tgl_ff;
            wAdr_ff <= adr_ff[3:0];
            wDat_ff <= {dat_ff[30:0], serialDataIoIn};
        end
    end

    // cycles since the toggle was seen; saturates so old writes go quiet
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff  <= 3'h0;
            since_ff <= 4'hF;
        end else begin
            sync_ff  <= {sync_ff[1:0], tgl_ff};
            if (sync_ff[2] ^ sync_ff[1]) since_ff <= 4'h0;
            else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
        end
    end

    // ------
    // assertions
    // ------
    a_oe_sel_low: assert property (@(posedge mclk) disable iff (!rst_n)
        serialDataIoOe |-> !chipSelectLow_n) else $error("line driven while unselected");
    a_term_off: assert property (@(posedge mclk) disable iff (!rst_n)
        serialDataIoOe |-> !(termPullUpEn || termPullDownEn || termKeepEn))
        else $error("termination on while driving");
    a_term_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rst_n, 3) && $stable(termMode) && termMode == $past(termMode, 2)
        && termMode == $past(termMode, 3) && !serialDataIoOe
        |-> {termPullUpEn, termPullDownEn, termKeepEn} == termExp)
        else $error("termination does not follow mode");
    a_oe_window: assert property (@(posedge serialClk) disable iff (!rst_n || chipSelectLow_n)
        serialDataIoOe == rdWin) else $error("drive window wrong");
    a_read_bits: assert property (@(posedge serialClk) disable iff (!rst_n || chipSelectLow_n)
        rdWin |-> serialDataIoOut == cfgWords[{adr_ff[3:0], 5'(6'h2F - cnt_ff)}])
        else $error("read bit wrong");
    a_oe_first: assert property (@(posedge serialClk) disable iff (!rst_n || chipSelectLow_n)
        $rose(serialDataIoOe) |-> cnt_ff == 6'h10 && rd_ff) else $error("drive starts early");
    a_cfg_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(cfgWords) |-> since_ff <= 4'h3) else $error("register changed without write");
    a_write_lands: assert property (@(posedge mclk) disable iff (!rst_n)
        since_ff == 4'h6 |-> cfgWords[{wAdr_ff, 5'h00} +: 32] == wDat_ff)
        else $error("written word missing");
    c_read: cover property (@(posedge serialClk) $rose(serialDataIoOe));
    c_write: cover property (@(posedge mclk) since_ff == 4'h6);
    c_keep: cover property (@(posedge mclk) termKeepEn && !serialDataIoOe);
endmodule // twrp_port_monitor

bind twrp_port twrp_port_monitor mon (.mclk, .rst_n, .serialClk, .chipSelectLow_n,
    .serialDataIoIn, .serialDataIoOut, .serialDataIoOe, .termMode, .termPullUpEn,
    .termPullDownEn, .termKeepEn, .cfgWords);

// ### bench/twrp_host_model.sv
// host model: master of the three-wire link
`timescale 1ns/1ps
module twrp_host_model (
    // pins driven by the host
    output logic      serialClk,
    output logic      chipSelectLow_n,
    output logic      hostData,
    output logic      hostOe,
    // resolved line
    input  wire logic lineLvl
);
    // clock idles low; one pulse during reset with select high
    initial begin
        serialClk       = 1'b0;
        chipSelectLow_n = 1'b1;
        hostData        = 1'b0;
        hostOe          = 1'b0;
        #100 serialClk = 1'b1;
        #16 serialClk = 1'b0;
    end

    // one access of n rises; fewer than 48 cuts it short
    task automatic frame(input int n, input logic [11:0] adr, input logic rd,
                         input logic [31:0] wd, output logic [31:0] rdat);
        logic [47:0] bits;
        bits = {adr, rd, 3'h5, wd};
        rdat = 32'h0000_0000;
        chipSelectLow_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            hostOe   = !(rd && i > 12);
            hostData = bits[47 - i];
            #16 serialClk = 1'b1;
            if (i > 15) rdat = {rdat[30:0], lineLvl};
            #16 serialClk = 1'b0;
        end
        hostOe = 1'b0;
        #16 chipSelectLow_n = 1'b1;
        #320;
    endtask

    // clock and data wander while unselected
    task automatic noise();
        for (int i = 0; i < 48; i++) begin
            hostOe   = 1'b1;
            hostData = i[0] ^ i[2];
            #16 serialClk = 1'b1;
            #16 serialClk = 1'b0;
        end
        hostOe = 1'b0;
    endtask
endmodule // twrp_host_model

// ### bench/tb_three_wire_register_port.sv
// self-checking bench for the three-wire register port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h seen %h", nm, e, g); end end
module tb_three_wire_register_port;
    import twrp_pkg::*;
    typedef struct { string nm; logic [31:0] v; } twrp_note_t;
    logic         mclk, rst_n, sclk, selLow_n, hData, hOe, dOut, dOe;
    logic         up, dn, kp, lvl, last_ff;
    logic [1:0]   termMode;
    logic [511:0] cfgWords;
    logic [31:0]  model [16];
    logic [31:0]  gotV;
    logic [31:0]  cutV;
    twrp_note_t   expQ[$];
    twrp_note_t   note;
    event         resEv;
    int           n_fail, checked;

    always #10 mclk = ~mclk;

    // device wins when enabled; a released line follows termination or wanders
    assign lvl = dOe ? dOut : hOe ? hData : up ? 1'b1 : dn ? 1'b0 : kp ? last_ff : ~last_ff;
    always @(posedge sclk) last_ff <= lvl;

    twrp_port dut (.mclk, .rst_n, .serialClk(sclk), .chipSelectLow_n(selLow_n),
        .serialDataIoIn(lvl), .serialDataIoOut(dOut), .serialDataIoOe(dOe), .termMode,
        .termPullUpEn(up), .termPullDownEn(dn), .termKeepEn(kp), .cfgWords);
    twrp_host_model host (.serialClk(sclk), .chipSelectLow_n(selLow_n), .hostData(hData),
        .hostOe(hOe), .lineLvl(lvl));

    // each result is compared with the oldest note
    always begin
        @(resEv);
        note = expQ.pop_front();
        `CHK(note.nm, note.v, gotV)
    end

    task automatic noteExp(string nm, logic [31:0] v);
        expQ.push_back('{nm, v});
    endtask
    task automatic result(logic [31:0] v);
        gotV = v;
        ->resEv;
        #1;
    endtask
    // write of n rises, then the stored word is compared
    task automatic wr(logic [11:0] a, logic [31:0] d, int n);
        logic [31:0] r;
        host.frame(n, a, 1'b0, d, r);
        if (n == 48 && a[11:4] == 8'h00) model[a[3:0]] = d;
        noteExp("cfg", model[a[3:0]]);
        result(cfgWords[{a[3:0], 5'h00} +: 32]);
    endtask
    task automatic rd(logic [3:0] a);
        logic [31:0] r;
        noteExp("read", model[a]);
        host.frame(48, {8'h00, a}, 1'b1, $urandom, r);
        result(r);
    endtask
    task automatic endt(string s);
        $display("test %s done", s);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard
    initial begin
        #400000;
        `CHK("watchdog", 1'b0, 1'b1)
        stop_test();
    end

    initial begin
        mclk     = 1'b0;
        rst_n    = 1'b0;
        termMode = 2'h0;
        last_ff  = 1'b0;
        n_fail   = 0;
        checked  = 0;
        gotV     = $urandom(32'hB29E);
        foreach (model[i]) model[i] = 32'h0000_0000;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(4'hF);
        endt("reset");
        for (int a = 0; a < 16; a++) wr({8'h00, 4'(a)}, $urandom, 48);
        wr(12'h00A, 32'h8000_0001, 48);
        for (int a = 15; a >= 0; a--) rd(4'(a));
        endt("write_read");
        wr(12'h005, $urandom, 30);
        wr(12'h005, $urandom, 47);
        // a read cut in its data phase must leave the line released
        host.frame(30, 12'h005, 1'b1, 32'h0000_0000, cutV);
        noteExp("oe_cut", 32'h0000_0000);
        result({31'h0, dOe});
        rd(4'h5);
        endt("cut");
        wr(12'h805, $urandom, 48);
        rd(4'h5);
        endt("bad_addr");
        host.noise();
        rd(4'h6);
        endt("unselected");
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk) termMode <= 2'(m);
            repeat (4) @(posedge mclk);
            #2;
            noteExp("term", {29'h0, m == 0, m == 1, m == 2});
            result({29'h0, up, dn, kp});
            rd(4'(m + 8));
        end
        endt("termination");
        @(posedge mclk) rst_n <= 1'b0;
        host.noise();
        @(posedge mclk) rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (model[i]) model[i] = 32'h0000_0000;
        rd(4'h7);
        wr(12'h007, $urandom, 48);
        rd(4'h7);
        endt("second_reset");
        stop_test();
    end
endmodule // tb_three_wire_register_port
